// File: pkg/icx_map.svh
// Register map, field positions, reset values and counts of the I2C port
// Behaviour
// [R1] Matching address with read bit set: record read, buffer address, acknowledge ninth bit.
// [R2] After acknowledging a read address, clear clock_release and hold SCL low.
// [R3] Buffer write also loads shift register; shift eight bits out on SCL falls.
// [R4] Latch host acknowledge at ninth SCL rise; on NACK go idle until Start.
// [R5] Set serial_port_irq_flag at ninth SCL fall of each byte; software clears it.
// [R6] Collision while shifting out with detect enabled: set bus_collision_flag, go idle.
// [R7] Host ACK stretches the clock; host NACK releases it, flag still set.
// [R8] Address hold: after eighth SCL fall of match, clear clock_release, set flag.
// [R9] Address hold: software picks ack_value_select first; device drives it on acknowledge.
// [R10] Address hold with read: clear clock_release again and set flag after acknowledge.
// [R11] Software loads transmit data only after the address acknowledge completes.
// [R12] External host NACKs the last byte so the client releases SCL.
// [R13] start_seen and stop_seen clear on reset and while the port is disabled.
// [R14] Host mode sets the flag on Start, Stop and generation completion events.
// [R15] Host mode: buffer write during a sequence is dropped and sets write_collision.
// [R16] Start/Stop detection paused while generating; flag set when generate bit clears.
// [R17] Host first byte carries seven address bits plus read/write bit.
// [R18] Baud generator waits until released SCL reads high, then reloads.
// [R19] Writes to low five serial_control2 bits ignored while a Start runs.
// [R20] Start: load baud generator, at timeout pull SDA low, one period later finish.
// [R21] Both lines low at begin, or SCL low early: bus collision, abort Start.
// [R22] Host only pulls SDA and SCL low, otherwise lets them float.
`ifndef ICX_MAP_SVH
`define ICX_MAP_SVH

`define ICX_OFF_CTRL 8'h00
`define ICX_OFF_CON2 8'h04
`define ICX_OFF_STAT 8'h08
`define ICX_OFF_BUF 8'h0C
`define ICX_OFF_BAUD 8'h10

`define ICX_CTRL_EN 0
`define ICX_CTRL_HOST 1
`define ICX_CTRL_ADDRESS_HOLD_ENABLE 2
`define ICX_CTRL_CCE 3
`define ICX_CTRL_START_IRQ_ENABLE 4
`define ICX_CTRL_CKP 5
`define ICX_CTRL_OWN 8

`define ICX_CON2_SEN 0
`define ICX_CON2_PEN 2
`define ICX_CON2_ACK_VALUE_SELECT 5

`define ICX_ST_IRQ 0
`define ICX_ST_BCL 1
`define ICX_ST_WRITE_COLLISION 2
`define ICX_ST_ACK_RECEIVED_STATUS 3
`define ICX_ST_START 4
`define ICX_ST_STOP 5
`define ICX_ST_BF 6
`define ICX_ST_RW 7
`define ICX_ST_ACK_TIME_FLAG 8
`define ICX_ST_HRD 9

`define ICX_RST_CKP 1'b1
`define ICX_RST_OWN 7'h00
`define ICX_RST_RELOAD 8'h00
`define ICX_RESP_OKAY 2'h0
`define ICX_RESP_SLVERR 2'h2
`define ICX_LAST_BIT 4'h7
`define ICX_ADDR_BITS 4'h8

`endif

// File: pkg/icx_pkg.sv
// Types shared by the I2C port modules
package icx_pkg;
  typedef enum logic [8:0] {
    st_idle = 9'h001,
    st_addr = 9'h002,
    st_aack = 9'h004,
    st_tx = 9'h008,
    st_tack = 9'h010,
    st_hchk = 9'h020,
    st_hwait = 9'h040,
    st_hhold = 9'h080,
    st_hidle = 9'h100
  } icx_state_t;

  // Bus line pair carried together
  typedef struct packed {
    logic scl;
    logic sda;
  } icx_pins_t;
endpackage

// File: hdl/icx_sync.sv
// Two-flop synchroniser for the SCL and SDA lines
module icx_sync import icx_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire icx_pins_t raw,
  output icx_pins_t synced
);
  logic [1:0] s_vec;

  // Idle bus reads high, so both stages reset high
  genvar i;
  for (i = 0; i < 2; i++) begin : g_bit
    logic m_q;
    logic s_q;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        m_q <= 1'b1;
        s_q <= 1'b1;
      end else begin
        m_q <= raw[i];
        s_q <= m_q;
      end
    end
    assign s_vec[i] = s_q;
  end

  assign synced = icx_pins_t'(s_vec);
endmodule

// File: hdl/icx_baud.sv
// Baud generator with clock arbitration on a released SCL
module icx_baud (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic halt,
  input wire logic [7:0] reload,
  input wire logic scl_rel,
  input wire logic scl_hi,
  output logic timeout
);
  logic [7:0] cnt_q;
  logic run_q;
  logic hi_q;
  logic wait_w;
  logic rise_w;

  // Counting freezes while another device holds a released SCL low
  assign wait_w = scl_rel & ~scl_hi; // R18
  assign rise_w = run_q & scl_rel & scl_hi & ~hi_q; // R18
  assign timeout = run_q & ~wait_w & ~rise_w & (cnt_q == 8'h00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 8'h00;
      run_q <= 1'b0;
      hi_q <= 1'b1;
    end else begin
      hi_q <= scl_hi;
      if (load || rise_w) begin
        cnt_q <= reload; // R18
        run_q <= 1'b1;
      end else if (halt) begin
        run_q <= 1'b0;
      end else if (run_q && !wait_w) begin
        cnt_q <= (cnt_q == 8'h00) ? reload : cnt_q - 8'h01;
      end
    end
  end
endmodule

// File: hdl/icx_top.sv
// I2C port: client transmit, host Start generation, AXI4-Lite registers
`include "icx_map.svh"

module icx_top import icx_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output logic scl_drive,
  output logic sda_drive,
  output logic scl_oe_n,
  output logic sda_oe_n
);
  // Bus slave state
  logic aw_q;
  logic w_q;
  logic [7:0] awa_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Software fields
  logic en_q, host_q, address_hold_enable_q, cce_q, start_irq_enable_q, ckp_q, ack_value_select_q;
  logic [6:0] own_q;
  logic [4:0] low5_q;
  logic [7:0] reload_q;

  // Status flags
  logic irq_q, bcl_q, write_collision_q, ack_received_status_q, s_q, p_q;
  logic bf_q, rw_q, ack_time_flag_q, hrd_q;

  // Port datapath
  icx_state_t st_q, st_d;
  logic [7:0] sh_q, sh_d, sh_n, buf_q;
  logic [3:0] bit_q, bit_d;
  logic scl_p_q, sda_p_q;
  logic scl_oe_n_q, sda_oe_n_q;
  icx_pins_t lines;

  // Events from the state machine
  logic ev_irq, ev_bcl, ev_match, ack_ld, ckp_clr;
  logic sen_clr, s_gen, brg_load, brg_stop, bf_clr_tx;
  logic brg_to;

  icx_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw({scl_pin, sda_pin}),
    .synced(lines)
  );

  // Edge and condition detection on the synchronised lines
  wire scl_s = lines.scl;
  wire sda_s = lines.sda;
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire gen_busy = (st_q == st_hchk) | (st_q == st_hwait) | (st_q == st_hhold);
  wire start_det = scl_s & sda_p_q & ~sda_s & ~gen_busy; // R16
  wire stop_det = scl_s & ~sda_p_q & sda_s & ~gen_busy; // R16
  wire addr_match = (sh_q[7:1] == own_q);
  wire last_bit = (bit_q == `ICX_LAST_BIT);
  wire addr_done = (bit_q == `ICX_ADDR_BITS); // Counted on rises, so the Start's own SCL fall is no bit
  wire ack_val = address_hold_enable_q ? ack_value_select_q : 1'b0; // R9
  wire sen_q = low5_q[`ICX_CON2_SEN];

  // Write decode; a write commits once both address and data are held
  wire wr_go = aw_q & w_q & ~bvalid_q;
  wire wr_ctrl = wr_go & (awa_q == `ICX_OFF_CTRL);
  wire wr_con2 = wr_go & (awa_q == `ICX_OFF_CON2);
  wire wr_stat = wr_go & (awa_q == `ICX_OFF_STAT);
  wire wr_buf = wr_go & (awa_q == `ICX_OFF_BUF) & ws_q[0];
  wire wr_baud = wr_go & (awa_q == `ICX_OFF_BAUD);
  wire wr_hit = wr_ctrl | wr_con2 | wr_stat | (awa_q == `ICX_OFF_BUF) | wr_baud;
  wire host_busy = host_q & (gen_busy | sen_q);
  wire buf_write_collision = wr_buf & host_busy; // R15
  wire buf_load = wr_buf & ~host_busy;
  wire clr_w1c = wr_stat & ws_q[0];

  // Read decode
  wire ar_go = s_axi_arvalid & ~rvalid_q;
  wire rd_buf = ar_go & (s_axi_araddr == `ICX_OFF_BUF);
  logic [31:0] rd_ctrl, rd_con2, rd_stat;
  wire rd_hit = (s_axi_araddr == `ICX_OFF_CTRL) | (s_axi_araddr == `ICX_OFF_CON2) |
                (s_axi_araddr == `ICX_OFF_STAT) | (s_axi_araddr == `ICX_OFF_BUF) |
                (s_axi_araddr == `ICX_OFF_BAUD);
  wire [31:0] rd_word = (s_axi_araddr == `ICX_OFF_CTRL) ? rd_ctrl :
                        (s_axi_araddr == `ICX_OFF_CON2) ? rd_con2 :
                        (s_axi_araddr == `ICX_OFF_STAT) ? rd_stat :
                        (s_axi_araddr == `ICX_OFF_BUF) ? {24'h000000, buf_q} :
                        (s_axi_araddr == `ICX_OFF_BAUD) ? {24'h000000, reload_q} : 32'h00000000;

  assign s_axi_awready = ~aw_q;
  assign s_axi_wready = ~w_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Reserved bits read as zero
  always_comb begin
    rd_ctrl = 32'h00000000;
    rd_ctrl[`ICX_CTRL_EN] = en_q;
    rd_ctrl[`ICX_CTRL_HOST] = host_q;
    rd_ctrl[`ICX_CTRL_ADDRESS_HOLD_ENABLE] = address_hold_enable_q;
    rd_ctrl[`ICX_CTRL_CCE] = cce_q;
    rd_ctrl[`ICX_CTRL_START_IRQ_ENABLE] = start_irq_enable_q;
    rd_ctrl[`ICX_CTRL_CKP] = ckp_q;
    rd_ctrl[`ICX_CTRL_OWN +: 7] = own_q;
    rd_con2 = 32'h00000000;
    rd_con2[4:0] = low5_q;
    rd_con2[`ICX_CON2_ACK_VALUE_SELECT] = ack_value_select_q;
    rd_stat = 32'h00000000;
    rd_stat[`ICX_ST_IRQ] = irq_q;
    rd_stat[`ICX_ST_BCL] = bcl_q;
    rd_stat[`ICX_ST_WRITE_COLLISION] = write_collision_q;
    rd_stat[`ICX_ST_ACK_RECEIVED_STATUS] = ack_received_status_q;
    rd_stat[`ICX_ST_START] = s_q;
    rd_stat[`ICX_ST_STOP] = p_q;
    rd_stat[`ICX_ST_BF] = bf_q;
    rd_stat[`ICX_ST_RW] = rw_q;
    rd_stat[`ICX_ST_ACK_TIME_FLAG] = ack_time_flag_q;
    rd_stat[`ICX_ST_HRD] = hrd_q;
  end

  // Write channels are taken independently and joined before the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_q) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_q) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_q <= 1'b0;
      end
    end
  end

  // Responses; unmapped addresses answer with a slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `ICX_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `ICX_RESP_OKAY;
    end else begin
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `ICX_RESP_OKAY : `ICX_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (ar_go) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? `ICX_RESP_OKAY : `ICX_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Control fields; a software write of clock_release overrides a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {en_q, host_q, address_hold_enable_q, cce_q, start_irq_enable_q} <= 5'h00;
      ckp_q <= `ICX_RST_CKP;
      own_q <= `ICX_RST_OWN;
    end else begin
      if (wr_ctrl && ws_q[0]) begin
        en_q <= wd_q[`ICX_CTRL_EN];
        host_q <= wd_q[`ICX_CTRL_HOST];
        address_hold_enable_q <= wd_q[`ICX_CTRL_ADDRESS_HOLD_ENABLE];
        cce_q <= wd_q[`ICX_CTRL_CCE];
        start_irq_enable_q <= wd_q[`ICX_CTRL_START_IRQ_ENABLE];
        ckp_q <= wd_q[`ICX_CTRL_CKP];
      end else if (ckp_clr) begin
        ckp_q <= 1'b0; // R2
      end
      if (wr_ctrl && ws_q[1]) begin
        own_q <= wd_q[`ICX_CTRL_OWN +: 7];
      end
    end
  end

  // serial_control2 and the baud reload value
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low5_q <= 5'h00;
      ack_value_select_q <= 1'b0;
      reload_q <= `ICX_RST_RELOAD;
    end else begin
      if (wr_con2 && ws_q[0] && !sen_q) begin
        low5_q <= wd_q[4:0]; // R19
      end else if (sen_clr) begin
        low5_q[`ICX_CON2_SEN] <= 1'b0; // R16
      end
      if (wr_con2 && ws_q[0]) begin
        ack_value_select_q <= wd_q[`ICX_CON2_ACK_VALUE_SELECT];
      end
      if (wr_baud && ws_q[0]) begin
        reload_q <= wd_q[7:0];
      end
    end
  end

  // Sticky flags: a hardware set wins over a same-cycle software clear
  wire irq_set = ev_irq | (host_q & (start_det | stop_det)) | (~host_q & start_irq_enable_q & start_det); // R14
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {irq_q, bcl_q, write_collision_q, ack_received_status_q, bf_q, rw_q, ack_time_flag_q, hrd_q} <= 8'h00;
    end else begin
      irq_q <= (irq_q & ~(clr_w1c & wd_q[`ICX_ST_IRQ])) | irq_set; // R5
      bcl_q <= (bcl_q & ~(clr_w1c & wd_q[`ICX_ST_BCL])) | ev_bcl; // R6
      write_collision_q <= (write_collision_q & ~(clr_w1c & wd_q[`ICX_ST_WRITE_COLLISION])) | buf_write_collision; // R15
      if (ack_ld) begin
        ack_received_status_q <= sda_s; // R4
      end
      bf_q <= (bf_q & ~rd_buf & ~bf_clr_tx) | ev_match | buf_load;
      if (ev_match) begin
        rw_q <= sh_q[0]; // R1
      end
      ack_time_flag_q <= ev_match | (ack_time_flag_q & ~(st_q == st_aack && scl_fall));
      if (buf_load && host_q) begin
        hrd_q <= wd_q[0]; // R17
      end
    end
  end

  // Bus condition bits, cleared while the port is off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= 1'b0;
      p_q <= 1'b0;
    end else if (!en_q) begin
      s_q <= 1'b0; // R13
      p_q <= 1'b0; // R13
    end else begin
      s_q <= s_gen | start_det | (s_q & ~stop_det);
      p_q <= stop_det | (p_q & ~start_det & ~s_gen);
    end
  end

  // Port sequencing
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    bit_d = bit_q;
    {ev_irq, ev_bcl, ev_match, ack_ld, ckp_clr} = 5'h00;
    {sen_clr, s_gen, brg_load, brg_stop, bf_clr_tx} = 5'h00;
    case (st_q)
      st_idle: begin
        if (host_q && sen_q) begin
          st_d = st_hchk;
        end
      end
      st_addr: begin
        if (scl_rise) begin
          sh_d = {sh_q[6:0], sda_s};
          bit_d = bit_q + 4'h1;
        end
        if (scl_fall && addr_done) begin
          bit_d = 4'h0;
          if (addr_match) begin
            ev_match = 1'b1; // R1
            ckp_clr = address_hold_enable_q; // R8
            ev_irq = address_hold_enable_q; // R8
            st_d = st_aack;
          end else begin
            st_d = st_idle;
          end
        end
      end
      st_aack: begin
        if (scl_fall && !ack_val) begin
          ev_irq = 1'b1; // R5
          ckp_clr = rw_q; // R10
          st_d = rw_q ? st_tx : st_idle;
        end else if (scl_fall) begin
          st_d = st_idle;
        end
      end
      st_tx: begin
        if (scl_rise && sh_q[7] && !sda_s && cce_q) begin
          ev_bcl = 1'b1; // R6
          st_d = st_idle;
        end else if (scl_fall) begin
          sh_d = {sh_q[6:0], 1'b0}; // R3
          bit_d = last_bit ? 4'h0 : bit_q + 4'h1;
          bf_clr_tx = last_bit;
          st_d = last_bit ? st_tack : st_tx;
        end
      end
      st_tack: begin
        ack_ld = scl_rise; // R4
        if (scl_fall) begin
          ev_irq = 1'b1; // R7
          ckp_clr = ~ack_received_status_q; // R7
          st_d = ack_received_status_q ? st_idle : st_tx; // R4
        end
      end
      st_hchk: begin
        if (scl_s && sda_s) begin
          brg_load = 1'b1; // R20
          st_d = st_hwait;
        end else if (!scl_s && !sda_s) begin
          ev_bcl = 1'b1; // R21
          sen_clr = 1'b1;
          st_d = st_idle;
        end
      end
      st_hwait: begin
        if (!scl_s || (brg_to && !sda_s)) begin
          ev_bcl = 1'b1; // R21
          sen_clr = 1'b1;
          brg_stop = 1'b1;
          st_d = st_idle;
        end else if (brg_to) begin
          s_gen = 1'b1; // R20
          brg_load = 1'b1;
          st_d = st_hhold;
        end
      end
      st_hhold: begin
        if (brg_to) begin
          sen_clr = 1'b1; // R20
          ev_irq = 1'b1; // R16
          brg_stop = 1'b1;
          st_d = st_hidle;
        end
      end
      st_hidle: begin
        if (!host_q) begin
          st_d = st_idle;
        end
      end
      default: begin
        st_d = st_idle;
      end
    endcase
    // Disable, Stop and a client Start override the sequence
    if (!en_q) begin
      st_d = st_idle;
      brg_stop = 1'b1;
    end else if (stop_det) begin
      st_d = st_idle;
    end else if (start_det && !host_q) begin
      st_d = st_addr;
      bit_d = 4'h0;
    end
  end

  // A buffer write loads the shift register directly
  assign sh_n = buf_load ? wd_q[7:0] : sh_d; // R3

  // Pulls are computed from next state to save a cycle of pin latency
  wire sda_lo_d = ((st_d == st_aack) & ~ack_val) | ((st_d == st_tx) & ~sh_n[7]) |
                  (st_d == st_hhold) | (st_d == st_hidle); // R9
  wire ckp_n = (wr_ctrl & ws_q[0]) ? wd_q[`ICX_CTRL_CKP] : (ckp_q & ~ckp_clr);
  wire scl_lo_d = ((st_d == st_aack) | (st_d == st_tx)) & ~ckp_n; // R2

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= st_idle;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      buf_q <= 8'h00;
    end else begin
      st_q <= st_d;
      sh_q <= sh_n;
      bit_q <= bit_d;
      if (buf_load) begin
        buf_q <= wd_q[7:0];
      end else if (ev_match) begin
        buf_q <= sh_q; // R1
      end
    end
  end

  // Lines are only ever pulled low; released means high impedance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      scl_oe_n_q <= ~scl_lo_d; // R22
      sda_oe_n_q <= ~sda_lo_d; // R22
    end
  end

  assign scl_drive = 1'b0;
  assign sda_drive = 1'b0;
  assign scl_oe_n = scl_oe_n_q;
  assign sda_oe_n = sda_oe_n_q;

  icx_baud u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(brg_load),
    .halt(brg_stop),
    .reload(reload_q),
    .scl_rel(scl_oe_n_q),
    .scl_hi(scl_s),
    .timeout(brg_to)
  );

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_irq_sticky;
    irq_q && !clr_w1c |=> irq_q;
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("irq flag lost"); // R5

  property p_ckp_after_ack;
    en_q && st_q == st_aack && scl_fall && !ack_val && rw_q && !wr_ctrl |=> !ckp_q ##1 !scl_oe_n_q;
  endproperty
  a_ckp_after_ack: assert property (p_ckp_after_ack) else $error("no stretch after read ack"); // R2

  property p_byte_end;
    en_q && !stop_det && st_q == st_tx && scl_fall && last_bit |=> st_q == st_tack && bit_q == 4'h0;
  endproperty
  a_byte_end: assert property (p_byte_end) else $error("byte not ended after eight bits"); // R3

  property p_nack_idle;
    en_q && st_q == st_tack && scl_fall && ack_received_status_q |=> st_q == st_idle && irq_q;
  endproperty
  a_nack_idle: assert property (p_nack_idle) else $error("nack did not end transfer"); // R4

  property p_client_bcl;
    en_q && !stop_det && st_q == st_tx && scl_rise && sh_q[7] && !sda_s && cce_q |=> bcl_q && st_q == st_idle;
  endproperty
  a_client_bcl: assert property (p_client_bcl) else $error("client collision missed"); // R6

  property p_addr_hold;
    en_q && st_q == st_addr && scl_fall && addr_done && addr_match && address_hold_enable_q && !wr_ctrl
      |=> !ckp_q && irq_q && st_q == st_aack;
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address hold not taken"); // R8

  property p_write_collision;
    buf_write_collision |=> write_collision_q && $stable(buf_q);
  endproperty
  a_write_collision: assert property (p_write_collision) else $error("collided write not flagged"); // R15

  property p_con2_locked;
    wr_con2 && sen_q |=> $stable(low5_q[4:1]);
  endproperty
  a_con2_locked: assert property (p_con2_locked) else $error("con2 written during start"); // R19

  property p_start_drive;
    en_q && st_q == st_hwait && brg_to && scl_s && sda_s |=> !sda_oe_n_q && s_q;
  endproperty
  a_start_drive: assert property (p_start_drive) else $error("start not driven"); // R20

  property p_start_abort;
    en_q && st_q == st_hwait && !scl_s |=> st_q == st_idle && bcl_q && !sen_q;
  endproperty
  a_start_abort: assert property (p_start_abort) else $error("start collision not aborted"); // R21

  property p_off_clear;
    !en_q |=> !s_q && !p_q;
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("condition bits kept while off"); // R13
endmodule

// File: test/icx_host_model.sv
// Behavioural I2C host for the bench
module icx_host_model (
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // One bit; waits out any stretching before timing the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    #120;
    scl_o = 1'b1;
    wait (scl_w === 1'b1);
    #160;
    r = sda_w;
    scl_o = 1'b0;
    // SDA only moves a clock after SCL falls, so no false Start or Stop is seen
    #40;
  endtask
  task automatic start();
    sda_o = 1'b0;
    #160;
    scl_o = 1'b0;
  endtask
  task automatic stop();
    sda_o = 1'b0;
    #160;
    scl_o = 1'b1;
    #160;
    sda_o = 1'b1;
    #160;
  endtask
  // Pull both lines, used to force a collision
  task automatic pull(input logic l);
    scl_o = l;
    sda_o = l;
  endtask
  task automatic send(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, a);
  endtask
  // Last byte is answered with a NACK so the client lets SCL go
  task automatic recv(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
    sda_o = 1'b1;
  endtask
endmodule

// File: test/test_i2c_client_tx_host_start.sv
// Bench for the I2C port: registers, client read, host Start
`include "icx_map.svh"

module test_i2c_client_tx_host_start;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, d;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic awr, wrd, bv, arr, rv, scl_dr, sda_dr, scl_oe_n, sda_oe_n, m_scl, m_sda, scl_w, sda_w, ack;
  logic [1:0] bresp, rresp, wrsp, rrsp;
  logic [7:0] v;
  logic [7:0] dat [2] = '{8'hA5, 8'h3C};
  int failures = 0, compares = 0, cycles = 0;
  // Open-drain lines with pull-ups
  assign scl_w = m_scl & scl_oe_n;
  assign sda_w = m_sda & sda_oe_n;
  icx_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .scl_pin(scl_w),
    .sda_pin(sda_w), .scl_drive(scl_dr), .sda_drive(sda_dr), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n));
  icx_host_model host_u (.scl_w(scl_w), .sda_w(sda_w), .scl_o(m_scl), .sda_o(m_sda));
  always #20 aclk = ~aclk;
  // Readies are registered, so the value at the falling edge is what the next rise sees
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    logic ta, tw, tb;
    tb = 1'b0;
    awa <= a;
    wd <= x;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    while (!tb) begin
      @(negedge aclk);
      ta = (awv & awr) === 1'b1;
      tw = (wv & wrd) === 1'b1;
      tb = bv === 1'b1;
      wrsp = bresp;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    br <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    logic ta, tr;
    tr = 1'b0;
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    while (!tr) begin
      @(negedge aclk);
      ta = (arv & arr) === 1'b1;
      tr = rv === 1'b1;
      x = rdat;
      rrsp = rresp;
      @(posedge aclk);
      if (ta) arv <= 1'b0;
    end
    rr <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, d);
    chk(d & m, e);
  endtask
  task automatic end_of_test();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(`ICX_OFF_STAT, 32'h30, 32'h0);
    rd(8'h40, d);
    chk(d, 32'h0);
    chk({30'h0, rrsp}, {30'h0, `ICX_RESP_SLVERR});
    wr(8'h40, 32'h1);
    chk({30'h0, wrsp}, {30'h0, `ICX_RESP_SLVERR});
    $display("register test done");
    // Client read with address hold, own address 0x2A
    wr(`ICX_OFF_CTRL, 32'h2A2D);
    fork
      begin
        host_u.start();
        host_u.send(8'h55, ack);
      end
      begin
        wait (scl_oe_n === 1'b0);
        @(posedge aclk);
        rc(`ICX_OFF_STAT, 32'h101, 32'h101);
        wr(`ICX_OFF_STAT, 32'h1);
        wr(`ICX_OFF_CTRL, 32'h2A2D);
      end
    join
    chk({31'h0, ack}, 32'h0);
    repeat (10) @(posedge aclk);
    chk({31'h0, scl_oe_n}, 32'h0);
    rc(`ICX_OFF_STAT, 32'h81, 32'h81);
    rc(`ICX_OFF_BUF, 32'hFF, 32'h55);
    for (int i = 0; i < 2; i++) begin
      wr(`ICX_OFF_STAT, 32'h1);
      wr(`ICX_OFF_BUF, {24'h0, dat[i]});
      fork
        host_u.recv(i[0], v);
        wr(`ICX_OFF_CTRL, 32'h2A2D);
      join
      chk({24'h0, v}, {24'h0, dat[i]});
      repeat (10) @(posedge aclk);
      chk({31'h0, scl_oe_n}, {31'h0, i[0]});
      rc(`ICX_OFF_STAT, 32'hB, {28'h0, i[0], 3'b001});
    end
    host_u.stop();
    $display("client read done");
    // Host Start with a buffer write and serial_control2 write made while it runs; both are refused
    wr(`ICX_OFF_STAT, 32'h7);
    wr(`ICX_OFF_BAUD, 32'hF);
    wr(`ICX_OFF_CTRL, 32'h3);
    wr(`ICX_OFF_CON2, 32'h1);
    wr(`ICX_OFF_CON2, 32'h1E);
    wr(`ICX_OFF_BUF, 32'h54);
    repeat (60) @(posedge aclk);
    rc(`ICX_OFF_CON2, 32'h1F, 32'h0);
    rc(`ICX_OFF_STAT, 32'h17, 32'h15);
    rc(`ICX_OFF_BUF, 32'hFF, 32'h3C);
    chk({28'h0, sda_oe_n, scl_oe_n, sda_dr, scl_dr}, 32'h4);
    wr(`ICX_OFF_CTRL, 32'h0);
    rc(`ICX_OFF_STAT, 32'h30, 32'h0);
    chk({31'h0, sda_oe_n}, 32'h1);
    // Start on a bus held low must collide
    wr(`ICX_OFF_STAT, 32'h7);
    host_u.pull(1'b0);
    wr(`ICX_OFF_CTRL, 32'h3);
    wr(`ICX_OFF_CON2, 32'h1);
    repeat (60) @(posedge aclk);
    rc(`ICX_OFF_CON2, 32'h1, 32'h0);
    rc(`ICX_OFF_STAT, 32'h2, 32'h2);
    host_u.pull(1'b1);
    // SCL taken low while the Start waits out its first period
    wr(`ICX_OFF_STAT, 32'h7);
    wr(`ICX_OFF_CON2, 32'h1);
    host_u.pull(1'b0);
    repeat (60) @(posedge aclk);
    rc(`ICX_OFF_CON2, 32'h1, 32'h0);
    rc(`ICX_OFF_STAT, 32'h2, 32'h2);
    host_u.pull(1'b1);
    $display("host start done");
    end_of_test();
  end
endmodule
